//--- hdl/card_attr_params.svh
// Offsets, field positions, reset values and timing counts of the card attribute port
`ifndef CARD_ATTR_PARAMS_SVH
`define CARD_ATTR_PARAMS_SVH
`define ADDR_W            11
`define ATTR_CFG_BASE     11'h200
`define ADDR_STATUS       11'h202
`define ADDR_CHANGE       11'h204
`define ADDR_SOCKET       11'h206
`define ADDR_CFG_SEL_BIT  9
`define ST_CHANGED_BIT    7
`define ST_CHANGE_SIGNAL_ENABLE_BIT     6
`define ST_BYTEMODE_BIT   5
`define ST_PWRSAVE_BIT    2
`define ST_INT_BIT        1
`define ST_RESET          8'h00
`define CH_RCHG_BIT       5
`define CH_WPCHG_BIT      4
`define CH_ONES_MASK      8'h0c
`define CH_RSTATE_BIT     1
`define CH_WPSTATE_BIT    0
`define CH_RESET          8'h0c
`define SK_DRIVE_BIT      4
`define SK_RESET          8'h00
`define CLK_PERIOD_NS     4
`define PWR_SETTLE_NS     400
`define PWR_SETTLE_CYC    ((`PWR_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_TIME_NS      1000000
`define IDLE_CYC          (`IDLE_TIME_NS / `CLK_PERIOD_NS)
`endif

//--- hdl/card_attr_pkg.sv
// Types shared by the card attribute port modules
package card_attr_pkg;
	typedef struct packed {
		logic        reg_space_n;
		logic        low_byte_select_n;
		logic        high_byte_select_n;
		logic        mem_read_n;
		logic        mem_write_n;
		logic        io_read_strobe_n;
		logic        io_write_strobe_n;
		logic [10:0] addr;
		logic [15:0] data;
	} pin_bundle_t;
	typedef enum logic [1:0] {
		PWR_STEADY = 2'b01,
		PWR_MOVE   = 2'b10
	} pwr_state_t;
endpackage

//--- hdl/pin_vec_if.sv
// Raw and synchronised host pin bundle
`timescale 1ns/100ps
interface pin_vec_if;
	card_attr_pkg::pin_bundle_t raw;
	card_attr_pkg::pin_bundle_t clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

//--- hdl/pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = $bits(card_attr_pkg::pin_bundle_t)
) (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	// Pins
	pin_vec_if.sync   pins
);
	import card_attr_pkg::*;
	logic [W-1:0] s1_q, s2_q, s3_q, out_q;
	logic [W-1:0] s1_d, s2_d, s3_d, out_d;

	if (W != $bits(pin_bundle_t)) begin : g_bad_w
		$error("pin_sync width must match the pin bundle");
	end

	// First stage feeds only the second; filtering looks at stages two and three
	always_comb begin
		s1_d = pins.raw;
		s2_d = s1_q;
		s3_d = s2_q;
		for (int i = 0; i < W; i++) begin
			out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
		end
	end

	// Idle bus levels: all strobes and selects high
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s1_q  <= {7'h7f, {(W-7){1'b0}}};
			s2_q  <= {7'h7f, {(W-7){1'b0}}};
			s3_q  <= {7'h7f, {(W-7){1'b0}}};
			out_q <= {7'h7f, {(W-7){1'b0}}};
		end else begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			out_q <= out_d;
		end
	end

	assign pins.clean = out_q;
endmodule

//--- hdl/card_attribute_config_port.sv
// Card attribute memory configuration registers, power state and I/O lane steering
`timescale 1ns/100ps
`include "card_attr_params.svh"
module card_attribute_config_port #(
	parameter int IDLE_CYCLES = `IDLE_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Host pins
	input  wire logic        reg_space_n_i,
	input  wire logic        low_byte_select_n_i,
	input  wire logic        high_byte_select_n_i,
	input  wire logic        mem_read_n_i,
	input  wire logic        mem_write_n_i,
	input  wire logic        io_read_strobe_n_i,
	input  wire logic        io_write_strobe_n_i,
	input  wire logic [10:0] addr_i,
	input  wire logic [15:0] data_i,
	output logic      [15:0] data_o,
	output logic      [1:0]  data_oe_o,
	output logic             wide_port_ack_n_o,
	output logic             card_irq_line_o,
	output logic             status_chg_n_o,
	// Card core
	input  wire logic        core_ready_i,
	input  wire logic        int_req_i,
	input  wire logic        irq_disable_n_i,
	input  wire logic        io_mode_i,
	input  wire logic        dedicated_mode_i,
	input  wire logic        cmd_arrive_i,
	input  wire logic [15:0] io_rd_data_i,
	output logic      [15:0] io_wr_data_o,
	output logic      [1:0]  io_wr_be_o,
	output logic             io_wr_stb_o,
	output logic      [10:0] io_addr_o,
	output logic             power_save_o,
	output logic             drive_number_o
);
	import card_attr_pkg::*;

	localparam logic [15:0] SETTLE_CYC = 16'(`PWR_SETTLE_CYC);

	if (IDLE_CYCLES < 1 || IDLE_CYCLES > 32'h7fffffff) begin : g_bad_idle
		$error("IDLE_CYCLES out of range");
	end

	pin_vec_if pv ();
	pin_bundle_t p;

	assign pv.raw = '{reg_space_n: reg_space_n_i, low_byte_select_n: low_byte_select_n_i,
		high_byte_select_n: high_byte_select_n_i, mem_read_n: mem_read_n_i,
		mem_write_n: mem_write_n_i, io_read_strobe_n: io_read_strobe_n_i,
		io_write_strobe_n: io_write_strobe_n_i, addr: addr_i, data: data_i};

	pin_sync #(
		.W ($bits(pin_bundle_t))
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.pins      (pv.sync)
	);

	assign p = pv.clean;

	// Cycle decode
	logic attr_sel, attr_rd, attr_wr, io_sel, io_rd, io_wr;
	logic wr_prev_q, wr_prev_d, iow_prev_q, iow_prev_d;
	logic wr_start, iow_start, cfg_region;

	always_comb begin
		attr_sel   = !p.reg_space_n && !p.low_byte_select_n && !p.addr[0]
			&& !dedicated_mode_i;
		attr_rd    = attr_sel && !p.mem_read_n && p.mem_write_n;
		attr_wr    = attr_sel && p.mem_read_n && !p.mem_write_n;
		cfg_region = p.addr[`ADDR_CFG_SEL_BIT];
		io_sel     = !p.reg_space_n && !(p.low_byte_select_n && p.high_byte_select_n)
			&& !dedicated_mode_i;
		io_rd      = io_sel && !p.io_read_strobe_n && p.io_write_strobe_n;
		io_wr      = io_sel && p.io_read_strobe_n && !p.io_write_strobe_n;
		// One commit per cycle; relies on the host idling strobes between cycles
		wr_prev_d  = attr_wr;
		iow_prev_d = io_wr;
		wr_start   = attr_wr && !wr_prev_q;
		iow_start  = io_wr && !iow_prev_q;
	end

	// Power state, idle timer and ready
	pwr_state_t  pwr_q, pwr_d;
	logic        pwr_act_q, pwr_act_d, auto_q, auto_d;
	logic [15:0] settle_q, settle_d;
	logic [31:0] idle_q, idle_d;
	logic        target, busy, ready_int, activity;

	// Register file
	logic [7:0] status_q, status_d, change_q, change_d, socket_q, socket_d;
	logic       rdy_prev_q, rdy_prev_d, wp_prev_q, wp_prev_d;
	logic       int_pend, rstate, wp_state_toggle_src;

	always_comb begin
		activity = cmd_arrive_i || attr_rd || attr_wr || io_rd || io_wr;
		target   = status_q[`ST_PWRSAVE_BIT] || auto_q;
		pwr_d    = pwr_q;
		pwr_act_d = pwr_act_q;
		settle_d = settle_q;
		auto_d   = auto_q;
		idle_d   = idle_q;
		if (cmd_arrive_i) begin
			auto_d = 1'b0;
		end else if (idle_q == 32'(IDLE_CYCLES - 1) && !auto_q) begin
			auto_d = 1'b1;
		end
		if (activity || auto_q) begin
			idle_d = 32'h0;
		end else if (idle_q != 32'(IDLE_CYCLES - 1)) begin
			idle_d = idle_q + 32'h1;
		end
		unique case (pwr_q)
			PWR_STEADY: begin
				if (target != pwr_act_q) begin
					pwr_d    = PWR_MOVE;
					settle_d = SETTLE_CYC;
				end
			end
			PWR_MOVE: begin
				if (settle_q > 16'h1) begin
					settle_d = settle_q - 16'h1;
				end else begin
					pwr_act_d = target;
					pwr_d     = PWR_STEADY;
				end
			end
			default: begin
				pwr_d = PWR_STEADY;
			end
		endcase
		busy      = (pwr_q == PWR_MOVE) || (target != pwr_act_q);
		ready_int = core_ready_i && !busy;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pwr_q     <= PWR_STEADY;
			pwr_act_q <= 1'b0;
			settle_q  <= 16'h0;
			auto_q    <= 1'b0;
			idle_q    <= 32'h0;
		end else begin
			pwr_q     <= pwr_d;
			pwr_act_q <= pwr_act_d;
			settle_q  <= settle_d;
			auto_q    <= auto_d;
			idle_q    <= idle_d;
		end
	end

	always_comb begin
		// No write-protect switch exists, so its state is a constant zero
		wp_state_toggle_src = 1'b0;
		int_pend   = int_req_i && !irq_disable_n_i;
		rstate     = io_mode_i ? int_pend : ready_int;
		rdy_prev_d = rst_i ? (io_mode_i ? int_pend : core_ready_i) : rstate;
		wp_prev_d  = wp_state_toggle_src;
		status_d   = status_q;
		change_d   = change_q;
		socket_d   = socket_q;
		if (wr_start && cfg_region) begin
			unique case (p.addr)
				`ADDR_STATUS: begin
					status_d[`ST_CHANGE_SIGNAL_ENABLE_BIT]   = p.data[`ST_CHANGE_SIGNAL_ENABLE_BIT];
					status_d[`ST_BYTEMODE_BIT] = p.data[`ST_BYTEMODE_BIT];
					status_d[`ST_PWRSAVE_BIT]  = p.data[`ST_PWRSAVE_BIT];
				end
				`ADDR_CHANGE: begin
					if (p.data[`CH_RSTATE_BIT]) begin
						change_d[`CH_RCHG_BIT] = p.data[`CH_RCHG_BIT];
					end
					if (p.data[`CH_WPSTATE_BIT]) begin
						change_d[`CH_WPCHG_BIT] = p.data[`CH_WPCHG_BIT];
					end
				end
				`ADDR_SOCKET: begin
					socket_d[`SK_DRIVE_BIT] = p.data[`SK_DRIVE_BIT];
				end
				default: begin
				end
			endcase
		end
		// Hardware set wins over a host clear in the same cycle
		if (rstate != rdy_prev_q) begin
			change_d[`CH_RCHG_BIT] = 1'b1;
		end
		if (wp_state_toggle_src != wp_prev_q) begin
			change_d[`CH_WPCHG_BIT] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			status_q   <= `ST_RESET;
			change_q   <= `CH_RESET;
			socket_q   <= `SK_RESET;
			rdy_prev_q <= rdy_prev_d; // Follows the live level so release shows no false edge
			wp_prev_q  <= 1'b0;
			wr_prev_q  <= 1'b0;
			iow_prev_q <= 1'b0;
		end else begin
			status_q   <= status_d;
			change_q   <= change_d;
			socket_q   <= socket_d;
			rdy_prev_q <= rdy_prev_d;
			wp_prev_q  <= wp_prev_d;
			wr_prev_q  <= wr_prev_d;
			iow_prev_q <= iow_prev_d;
		end
	end

	// Read view and pin outputs
	logic [7:0]  st_rd, ch_rd, sk_rd;
	logic [15:0] dout_q, dout_d, iowd_q, iowd_d;
	logic [1:0]  oe_q, oe_d, iobe_q, iobe_d;
	logic        ack_n_q, ack_n_d, irq_q, irq_d, chg_n_q, chg_n_d, iostb_q, iostb_d;
	logic [10:0] ioa_q, ioa_d;
	logic        changed;

	always_comb begin
		changed = change_q[`CH_RCHG_BIT] || change_q[`CH_WPCHG_BIT];
		st_rd   = 8'h00;
		st_rd[`ST_CHANGED_BIT]  = changed;
		st_rd[`ST_CHANGE_SIGNAL_ENABLE_BIT]   = status_q[`ST_CHANGE_SIGNAL_ENABLE_BIT];
		st_rd[`ST_BYTEMODE_BIT] = status_q[`ST_BYTEMODE_BIT];
		st_rd[`ST_PWRSAVE_BIT]  = status_q[`ST_PWRSAVE_BIT];
		st_rd[`ST_INT_BIT]      = int_pend;
		ch_rd   = `CH_ONES_MASK;
		ch_rd[`CH_RCHG_BIT]    = change_q[`CH_RCHG_BIT];
		ch_rd[`CH_WPCHG_BIT]   = change_q[`CH_WPCHG_BIT];
		ch_rd[`CH_RSTATE_BIT]  = rstate;
		ch_rd[`CH_WPSTATE_BIT] = wp_state_toggle_src;
		sk_rd   = 8'h00;
		sk_rd[`SK_DRIVE_BIT]   = socket_q[`SK_DRIVE_BIT];
		dout_d  = 16'h0000;
		oe_d    = 2'b00;
		if (attr_rd) begin
			oe_d = 2'b01;
			unique case (p.addr)
				`ADDR_STATUS: dout_d[7:0] = st_rd;
				`ADDR_CHANGE: dout_d[7:0] = ch_rd;
				`ADDR_SOCKET: dout_d[7:0] = sk_rd;
				default:      dout_d[7:0] = 8'h00;
			endcase
		end else if (io_rd) begin
			unique case ({p.high_byte_select_n, p.low_byte_select_n})
				2'b10: begin
					oe_d        = 2'b01;
					dout_d[7:0] = p.addr[0] ? io_rd_data_i[15:8] : io_rd_data_i[7:0];
				end
				2'b00: begin
					oe_d   = 2'b11;
					dout_d = io_rd_data_i;
				end
				default: begin
					oe_d         = 2'b10;
					dout_d[15:8] = io_rd_data_i[15:8];
				end
			endcase
		end
		// Every I/O port takes both byte and word cycles
		ack_n_d = !(io_mode_i && io_sel);
		irq_d   = io_mode_i && int_pend;
		chg_n_d = !(io_mode_i && changed && status_q[`ST_CHANGE_SIGNAL_ENABLE_BIT]);
		iostb_d = iow_start;
		iowd_d  = iowd_q;
		iobe_d  = iobe_q;
		ioa_d   = ioa_q;
		if (iow_start) begin
			ioa_d = {p.addr[10:1], 1'b0};
			unique case ({p.high_byte_select_n, p.low_byte_select_n})
				2'b10: begin
					iobe_d = p.addr[0] ? 2'b10 : 2'b01;
					iowd_d = {p.data[7:0], p.data[7:0]};
				end
				2'b00: begin
					iobe_d = 2'b11;
					iowd_d = p.data;
				end
				default: begin
					iobe_d = 2'b10;
					iowd_d = {p.data[15:8], 8'h00};
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			dout_q  <= 16'h0000;
			oe_q    <= 2'b00;
			ack_n_q <= 1'b1;
			irq_q   <= 1'b0;
			chg_n_q <= 1'b1;
			iostb_q <= 1'b0;
			iowd_q  <= 16'h0000;
			iobe_q  <= 2'b00;
			ioa_q   <= 11'h000;
		end else begin
			dout_q  <= dout_d;
			oe_q    <= oe_d;
			ack_n_q <= ack_n_d;
			irq_q   <= irq_d;
			chg_n_q <= chg_n_d;
			iostb_q <= iostb_d;
			iowd_q  <= iowd_d;
			iobe_q  <= iobe_d;
			ioa_q   <= ioa_d;
		end
	end

	assign data_o            = dout_q;
	assign data_oe_o         = oe_q;
	assign wide_port_ack_n_o = ack_n_q;
	assign card_irq_line_o   = irq_q;
	assign status_chg_n_o    = chg_n_q;
	assign io_wr_data_o      = iowd_q;
	assign io_wr_be_o        = iobe_q;
	assign io_wr_stb_o       = iostb_q;
	assign io_addr_o         = ioa_q;
	assign power_save_o      = pwr_act_q;
	assign drive_number_o    = socket_q[`SK_DRIVE_BIT];
endmodule

//--- tb/card_host_model.sv
// Host socket controller model driving the card pins
`timescale 1ns/100ps
module card_host_model (
	// Clock
	input  wire logic        sys_clk_i,
	// Card answer
	input  wire logic [15:0] rd_i,
	input  wire logic [1:0]  oe_i,
	input  wire logic        ack_n_i,
	// Pins towards the card
	output logic             reg_n_o,
	output logic             lo_n_o,
	output logic             hi_n_o,
	output logic             mrd_n_o,
	output logic             mwr_n_o,
	output logic             io_read_strobe_n_n_o,
	output logic             io_write_strobe_n_n_o,
	output logic      [10:0] addr_o,
	output logic      [15:0] dat_o
);
	logic [15:0] q;
	logic [1:0]  oe;
	logic        ack;
	initial begin
		{reg_n_o, lo_n_o, hi_n_o, mrd_n_o, mwr_n_o, io_read_strobe_n_n_o, io_write_strobe_n_n_o} = 7'h7f;
		addr_o = 11'h000;
		dat_o = 16'h0000;
	end
	// Drives the address and lanes as given; attribute cycles may use odd addresses or both lanes
	task acc(input logic io, input logic wr, input logic rg, input logic [1:0] ce,
		input logic [10:0] a, input logic [15:0] d);
		@(negedge sys_clk_i);
		reg_n_o = rg;
		{hi_n_o, lo_n_o} = ce;
		addr_o = a;
		dat_o = d;
		if (io) begin
			{io_read_strobe_n_n_o, io_write_strobe_n_n_o} = {wr, !wr};
		end else begin
			{mrd_n_o, mwr_n_o} = {wr, !wr};
		end
		// Held well past the synchroniser so the answer has settled
		repeat (7) @(posedge sys_clk_i);
		#1;
		q = rd_i;
		oe = oe_i;
		ack = ack_n_i;
		// Enables and both strobes drop between cycles
		@(negedge sys_clk_i);
		{reg_n_o, lo_n_o, hi_n_o, mrd_n_o, mwr_n_o, io_read_strobe_n_n_o, io_write_strobe_n_n_o} = 7'h7f;
		dat_o = ~dat_o;
		addr_o = ~addr_o;
		repeat (5) @(negedge sys_clk_i);
	endtask
endmodule

//--- tb/card_attr_chk.sv
// Port checker for the card attribute configuration port
`timescale 1ns/100ps
module card_attr_chk (
	// Clock and reset
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	// Observed ports
	input wire logic        reg_space_n_i,
	input wire logic        low_byte_select_n_i,
	input wire logic        mem_read_n_i,
	input wire logic        io_read_strobe_n_i,
	input wire logic [10:0] addr_i,
	input wire logic [15:0] data_i,
	input wire logic [15:0] data_o,
	input wire logic [1:0]  data_oe_o,
	input wire logic        wide_port_ack_n_o,
	input wire logic        card_irq_line_o,
	input wire logic        int_req_i,
	input wire logic        irq_disable_n_i,
	input wire logic        io_mode_i,
	input wire logic [15:0] io_wr_data_o,
	input wire logic [1:0]  io_wr_be_o,
	input wire logic        io_wr_stb_o,
	input wire logic [10:0] io_addr_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire attr_rd = !reg_space_n_i & !mem_read_n_i & !low_byte_select_n_i;
	// Pins reach the decode four edges late and the registered outputs five
	a_oe_cause: assert property (data_oe_o != 2'b00 |->
		!$past(mem_read_n_i, 5) || !$past(io_read_strobe_n_i, 5)) else $error("lanes without read");
	a_attr_low_lane: assert property (data_oe_o[1] |-> !$past(io_read_strobe_n_i, 5))
		else $error("upper lanes in attribute read");
	a_change_read: assert property (data_oe_o[0] && $past(attr_rd, 5) && $past(addr_i, 5) == 11'h204
		|-> data_o[7:6] == 2'b00 && data_o[3:2] == 2'b11 && !data_o[0]) else $error("change bits");
	a_sock_read: assert property (data_oe_o[0] && $past(attr_rd, 5) && $past(addr_i, 5) == 11'h206
		|-> (data_o[7:0] & 8'hef) == 8'h00) else $error("socket bits");
	a_stat_read: assert property (data_oe_o[0] && $past(attr_rd, 5) && $past(addr_i, 5) == 11'h202
		|-> (data_o[7:0] & 8'h19) == 8'h00) else $error("status bits");
	a_stb_single: assert property (io_wr_stb_o |=> !io_wr_stb_o) else $error("strobe too long");
	a_stb_even: assert property (io_wr_stb_o |-> !io_addr_o[0] && !$past(reg_space_n_i, 5))
		else $error("bad io write");
	a_stb_data: assert property (io_wr_stb_o && io_wr_be_o == 2'b11 |-> io_wr_data_o == $past(data_i, 5))
		else $error("io word data");
	a_irq_on: assert property ((io_mode_i && int_req_i && !irq_disable_n_i)[*3] |=> card_irq_line_o)
		else $error("irq missing");
	a_irq_off: assert property ((!io_mode_i || !int_req_i || irq_disable_n_i)[*3] |=> !card_irq_line_o)
		else $error("irq spurious");
	a_wide_io: assert property (!wide_port_ack_n_o |-> $past(io_mode_i)) else $error("wide ack");
endmodule
bind card_attribute_config_port card_attr_chk u_chk (.sys_clk_i, .rst_i, .reg_space_n_i,
	.low_byte_select_n_i, .mem_read_n_i, .io_read_strobe_n_i, .addr_i, .data_i, .data_o,
	.data_oe_o, .wide_port_ack_n_o, .card_irq_line_o, .int_req_i, .irq_disable_n_i, .io_mode_i,
	.io_wr_data_o, .io_wr_be_o, .io_wr_stb_o, .io_addr_o);

//--- tb/card_attribute_config_port_test.sv
// Testbench for the card attribute configuration port
`timescale 1ns/100ps
module card_attribute_config_port_test;
	logic        sys_clk_i = 0, rst_i = 1, cmd_i = 0;
	logic        rdy = 1, irq = 0, dis = 0, iom = 0, ded = 0;
	wire         reg_n, lo_n, hi_n, mrd_n, mwr_n, io_read_strobe_n_n, io_write_strobe_n_n, ack_n, irq_o, chg_n, stb, ps;
	wire         drv;
	wire  [10:0] a, ia;
	wire  [15:0] di, dq, wd;
	wire  [1:0]  oe, be;
	logic [15:0] cap_d;
	logic [1:0]  cap_be;
	logic [10:0] cap_a;
	int          n_mismatch = 0, samples_checked = 0;
	always #2 sys_clk_i = ~sys_clk_i;
	// Short idle span keeps the automatic power-save run brief
	card_attribute_config_port #(.IDLE_CYCLES(2000)) dut (.sys_clk_i, .rst_i, .reg_space_n_i(reg_n),
		.low_byte_select_n_i(lo_n), .high_byte_select_n_i(hi_n), .mem_read_n_i(mrd_n),
		.mem_write_n_i(mwr_n), .io_read_strobe_n_i(io_read_strobe_n_n), .io_write_strobe_n_i(io_write_strobe_n_n),
		.addr_i(a), .data_i(di), .data_o(dq), .data_oe_o(oe), .wide_port_ack_n_o(ack_n),
		.card_irq_line_o(irq_o), .status_chg_n_o(chg_n), .core_ready_i(rdy), .int_req_i(irq),
		.irq_disable_n_i(dis), .io_mode_i(iom), .dedicated_mode_i(ded), .cmd_arrive_i(cmd_i),
		.io_rd_data_i(16'h1234), .io_wr_data_o(wd), .io_wr_be_o(be), .io_wr_stb_o(stb),
		.io_addr_o(ia), .power_save_o(ps), .drive_number_o(drv));
	card_host_model host (.sys_clk_i, .rd_i(dq), .oe_i(oe), .ack_n_i(ack_n), .reg_n_o(reg_n),
		.lo_n_o(lo_n), .hi_n_o(hi_n), .mrd_n_o(mrd_n), .mwr_n_o(mwr_n), .io_read_strobe_n_n_o(io_read_strobe_n_n),
		.io_write_strobe_n_n_o(io_write_strobe_n_n), .addr_o(a), .dat_o(di));
	always @(posedge sys_clk_i) begin
		if (stb === 1'b1) begin
			{cap_d, cap_be, cap_a} <= {wd, be, ia};
		end
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [10:0] ad, input logic [7:0] d);
		host.acc(0, 1, 0, 2'b10, ad, {8'h00, d});
	endtask
	task rdc(input logic [10:0] ad, input logic [7:0] e);
		host.acc(0, 0, 0, 2'b10, ad, 16'h0000);
		chk("attr byte", {8'h00, e}, {8'h00, host.q[7:0]});
		chk("attr lanes", 16'h0001, {14'h0, host.oe});
	endtask
	task ioc(input logic wr, input logic [1:0] ce, input logic [10:0] ad, input logic [15:0] d);
		host.acc(1, wr, 0, ce, ad, d);
	endtask
	task t_change;
		host.acc(0, 0, 0, 2'b10, 11'h204, 16'h0000);
		chk("change reset", 16'h000e, {8'h00, host.q[7:0]});
		wr(11'h204, 8'h02);
		rdc(11'h204, 8'h0e);
		wr(11'h204, 8'h20);
		rdc(11'h204, 8'h0e);
		wr(11'h204, 8'h22);
		rdc(11'h204, 8'h2e);
		wr(11'h204, 8'h13);
		rdc(11'h204, 8'h1e);
		wr(11'h204, 8'h11);
		rdc(11'h204, 8'h1e);
		wr(11'h204, 8'h01);
		rdc(11'h204, 8'h0e);
	endtask
	task t_socket;
		wr(11'h206, 8'hff);
		rdc(11'h206, 8'h10);
		chk("drive bit", 16'h0001, {15'h0, drv});
		wr(11'h206, 8'h0f);
		rdc(11'h206, 8'h00);
		wr(11'h200, 8'h41);
		rdc(11'h200, 8'h00);
	endtask
	task t_power;
		rdc(11'h202, 8'h00);
		wr(11'h202, 8'hff);
		rdc(11'h204, 8'h2c);
		repeat (120) @(negedge sys_clk_i);
		chk("power save", 16'h0001, {15'h0, ps});
		rdc(11'h204, 8'h2e);
		rdc(11'h202, 8'he4);
		iom = 1;
		repeat (4) @(negedge sys_clk_i);
		chk("change pin", 16'h0000, {15'h0, chg_n});
		iom = 0;
		wr(11'h202, 8'h00);
		repeat (120) @(negedge sys_clk_i);
		chk("power active", 16'h0000, {15'h0, ps});
		wr(11'h204, 8'h02);
		rdc(11'h202, 8'h00);
	endtask
	task t_int;
		irq = 1;
		rdc(11'h202, 8'h02);
		dis = 1;
		rdc(11'h202, 8'h00);
		dis = 0;
		iom = 1;
		repeat (4) @(negedge sys_clk_i);
		chk("irq line", 16'h0001, {15'h0, irq_o});
		irq = 0;
		iom = 0;
	endtask
	task t_refuse;
		wr(11'h006, 8'h10);
		rdc(11'h206, 8'h00);
		host.acc(0, 1, 0, 2'b10, 11'h207, 16'h0010);
		rdc(11'h206, 8'h00);
		host.acc(0, 0, 0, 2'b10, 11'h207, 16'h0000);
		chk("odd attr lanes", 16'h0000, {14'h0, host.oe});
		ded = 1;
		host.acc(0, 0, 0, 2'b10, 11'h204, 16'h0000);
		chk("closed lanes", 16'h0000, {14'h0, host.oe});
		ded = 0;
		host.acc(0, 0, 0, 2'b00, 11'h204, 16'h0000);
		chk("word attr lanes", 16'h0001, {14'h0, host.oe});
	endtask
	task t_io;
		iom = 1;
		ioc(1, 2'b00, 11'h1f0, 16'ha55a);
		chk("io word", 16'ha55a, cap_d);
		chk("io be", 16'h0003, {14'h0, cap_be});
		chk("io addr", 16'h01f0, {5'h0, cap_a});
		ioc(1, 2'b01, 11'h1f1, 16'hc300);
		chk("io hi be", 16'h0002, {14'h0, cap_be});
		chk("io hi data", 16'h00c3, {8'h0, cap_d[15:8]});
		ioc(0, 2'b00, 11'h1f0, 16'h0000);
		chk("io rd word", 16'h1234, host.q);
		chk("wide ack", 16'h0000, {15'h0, host.ack});
		ioc(0, 2'b10, 11'h1f1, 16'h0000);
		chk("io rd odd", 16'h0112, {6'h0, host.oe, host.q[7:0]});
		ioc(0, 2'b01, 11'h1f0, 16'h0000);
		chk("io rd hi", 16'h0212, {6'h0, host.oe, host.q[15:8]});
		host.acc(1, 0, 1, 2'b00, 11'h1f0, 16'h0000);
		chk("io inhibit", 16'h0000, {14'h0, host.oe});
		iom = 0;
	endtask
	task t_auto;
		repeat (2300) @(negedge sys_clk_i);
		chk("auto save", 16'h0001, {15'h0, ps});
		cmd_i = 1;
		@(negedge sys_clk_i);
		cmd_i = 0;
		repeat (120) @(negedge sys_clk_i);
		chk("auto wake", 16'h0000, {15'h0, ps});
	endtask
	task stop_test;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#80000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (20) @(negedge sys_clk_i);
		rst_i = 0;
		t_change();
		t_socket();
		t_power();
		t_int();
		t_refuse();
		t_io();
		t_auto();
		stop_test();
	end
endmodule
